// ### charger_fault_params.svh
// Operation
// - Fault raises alert, stays latched until read
// - First read latched, second read present state
// - 256us low pulse, 256us block, defer
// - Event during low pulse only updates flags
// - Input limit alerts suppressed by mask bits
// - Listed charger events all raise alerts; here thermal regulation, depletion, short battery and overcurrent do not
// - Input overvoltage stops switching, code 01
// - System overvoltage stops switching, enables discharge
// - Boost short retries 7, then faults
// - Boost fault cleared by re-enabling boost
// - Boost overvoltage stops boost, sets fault
// - Boost output soft-starts on enable
// - Thermal regulation flags status
// - Charge-mode shutdown: converter, switch off, alert
// - Recover after 30 degree hysteresis
// - Boost shutdown clears OTG; host re-enables
// - Battery overvoltage stops charge, sets flag
// - Depletion latches switch off until plug-in
// - Short battery charged at reduced current
// - Deglitched overcurrent latches switch off
// - Host reads over two-wire, address 0x6A
// - Safety timer expiry sets code 11
`ifndef CHARGER_FAULT_PARAMS_SVH
`define CHARGER_FAULT_PARAMS_SVH

`define CLK_PERIOD_NS      8
`define ALERT_LOW_NS       256000
`define ALERT_BLOCK_NS     256000
`define OCP_DEGLITCH_NS    100000
`define I2C_QTR_NS         625
`define ALERT_LOW_CYC      ((`ALERT_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ALERT_BLOCK_CYC    ((`ALERT_BLOCK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OCP_DEGLITCH_CYC   ((`OCP_DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define I2C_QTR_CYC        ((`I2C_QTR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RAMP_STEP_CYC      125
`define BOOST_RETRY_MAX    3'h7
`define DEV_ADDR           7'h6A

`define CHG_CODE_NONE      2'h0
`define CHG_CODE_INPUT_OV  2'h1
`define CHG_CODE_TSHUT     2'h1
`define CHG_CODE_TIMER     2'h3

`define FLT_WD_BIT         7
`define FLT_BOOST_BIT      6
`define FLT_CODE_MSB       5
`define FLT_CODE_LSB       4
`define FLT_BAT_BIT        3
`define FLT_NTC_MSB        2

`define HREG_CTRL          2'h0
`define HREG_STATUS        2'h1
`define HREG_DATA          2'h2
`define HST_BUSY_BIT       0
`define HST_NACK_BIT       1
`define HST_ALERT_BIT      2

`endif

// ### charger_fault_pkg.sv
`default_nettype none
package charger_fault_pkg;
  typedef enum logic [1:0] {AL_IDLE, AL_LOW, AL_BLOCK} alert_state_t;
  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_AACK, SL_TX, SL_MACK} slave_state_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} master_state_t;
endpackage : charger_fault_pkg
`default_nettype wire

// ### charger_link_if.sv
`default_nettype none
interface charger_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic alert_n;
  logic scl;
  logic sda;

  // Open-drain wires: any enabled driver pulls low
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe, output alert_n);
  modport host (input scl, input sda, input alert_n, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface : charger_link_if
`default_nettype wire

// ### charger_fault_host.sv
`include "charger_fault_params.svh"
`default_nettype none
module charger_fault_host
  import charger_fault_pkg::*;
#(
  parameter int QTR_CYCLES = `I2C_QTR_CYC
) (
  input  wire logic       SYS_CLK_I,
  input  wire logic       RESET_N_I,
  charger_link_if.host    LINK,
  input  wire logic [1:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  output logic      [7:0] REG_RDATA_O
);
  master_state_t state;
  logic [7:0]  qcnt;
  logic        tick;
  logic [1:0]  phase;
  logic [4:0]  bitn;
  logic [7:0]  addr_sh;
  logic [7:0]  rx;
  logic        nack;
  logic        alert_seen;
  logic        alert_q;
  logic        scl_pull;
  logic        sda_pull;
  logic        busy;

  assign busy = (state != H_IDLE);
  assign tick = (qcnt == 8'(QTR_CYCLES - 1));
  assign LINK.host_scl_o  = 1'b0;
  assign LINK.host_sda_o  = 1'b0;
  assign LINK.host_scl_oe = scl_pull;
  assign LINK.host_sda_oe = sda_pull;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      qcnt <= 8'h00;
    end else if (!busy || tick) begin
      qcnt <= 8'h00;
    end else begin
      qcnt <= qcnt + 8'h01;
    end
  end

  // ***********************************
  // Read frame: start, address, byte, NACK, stop
  // ***********************************
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state    <= H_IDLE;
      phase    <= 2'h0;
      bitn     <= 5'h00;
      addr_sh  <= 8'h00;
      rx       <= 8'h00;
      nack     <= 1'b0;
      scl_pull <= 1'b0;
      sda_pull <= 1'b0;
    end else begin
      case (state)
        H_IDLE: begin
          scl_pull <= 1'b0;
          sda_pull <= 1'b0;
          if (REG_WR_I && REG_ADDR_I == `HREG_CTRL && REG_WDATA_I[0]) begin
            state   <= H_START;
            phase   <= 2'h0;
            addr_sh <= {`DEV_ADDR, 1'b1};
          end
        end
        H_START: begin
          if (tick) begin
            phase <= phase + 2'h1;
            if (phase == 2'h1) sda_pull <= 1'b1;
            if (phase == 2'h2) scl_pull <= 1'b1;
            if (phase == 2'h3) begin
              state <= H_BIT;
              bitn  <= 5'h00;
            end
          end
        end
        H_BIT: begin
          if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: begin
                sda_pull <= (bitn < 5'h08) ? !addr_sh[7] : 1'b0;
                if (bitn < 5'h08) addr_sh <= {addr_sh[6:0], 1'b0};
              end
              2'h1: scl_pull <= 1'b0;
              2'h2: begin
                if (bitn == 5'h08) nack <= LINK.sda;
                if (bitn > 5'h08 && bitn < 5'h11) rx <= {rx[6:0], LINK.sda};
              end
              default: begin
                scl_pull <= 1'b1;
                bitn     <= bitn + 5'h01;
                if (bitn == 5'h11) state <= H_STOP;
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            phase <= phase + 2'h1;
            if (phase == 2'h0) sda_pull <= 1'b1;
            if (phase == 2'h1) scl_pull <= 1'b0;
            if (phase == 2'h2) sda_pull <= 1'b0;
            if (phase == 2'h3) state <= H_IDLE;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // Alert edge capture; a new edge beats a clear in the same cycle
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      alert_q    <= 1'b1;
      alert_seen <= 1'b0;
    end else begin
      alert_q <= LINK.alert_n;
      if (alert_q && !LINK.alert_n) begin
        alert_seen <= 1'b1;
      end else if (REG_WR_I && REG_ADDR_I == `HREG_STATUS && REG_WDATA_I[`HST_ALERT_BIT]) begin
        alert_seen <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        `HREG_CTRL:   REG_RDATA_O <= {7'h00, busy};
        `HREG_STATUS: REG_RDATA_O <= {5'h00, alert_seen, nack, busy};
        `HREG_DATA:   REG_RDATA_O <= rx;
        default:      REG_RDATA_O <= 8'h00;
      endcase
    end else begin
      REG_RDATA_O <= 8'h00;
    end
  end
endmodule : charger_fault_host
`default_nettype wire

// ### charger_fault_dev.sv
`include "charger_fault_params.svh"
`default_nettype none
module charger_fault_dev
  import charger_fault_pkg::*;
#(
  parameter int ALERT_LOW_CYCLES   = `ALERT_LOW_CYC,
  parameter int ALERT_BLOCK_CYCLES = `ALERT_BLOCK_CYC,
  parameter int OCP_CYCLES         = `OCP_DEGLITCH_CYC,
  parameter int RAMP_STEP_CYCLES   = `RAMP_STEP_CYC,
  parameter int RAMP_W             = 4
) (
  input  wire logic              SYS_CLK_I,
  input  wire logic              RESET_N_I,
  charger_link_if.dev            LINK,
  input  wire logic              INPUT_OVERVOLTAGE_I,
  input  wire logic              SYSTEM_OVERVOLTAGE_I,
  input  wire logic              BATTERY_OVERVOLTAGE_I,
  input  wire logic              BOOST_SHORT_I,
  input  wire logic              BOOST_OVP_I,
  input  wire logic              DIE_OVER_REG_I,
  input  wire logic              DIE_OVER_SHUT_I,
  input  wire logic              DIE_BELOW_HYS_I,
  input  wire logic              BAT_DEPLETED_I,
  input  wire logic              BAT_SHORT_I,
  input  wire logic              BAT_OCP_I,
  input  wire logic              INPUT_PRESENT_I,
  input  wire logic              SHIP_EXIT_I,
  input  wire logic              SAFETY_TIMER_EXP_I,
  input  wire logic              WATCHDOG_EXP_I,
  input  wire logic              TOPOFF_ACTIVE_I,
  input  wire logic              INPUT_BELOW_MIN_I,
  input  wire logic [2:0]        NTC_FAULT_I,
  input  wire logic              INPUT_VOLTAGE_LIMIT_EVENT_I,
  input  wire logic              INPUT_CURRENT_LIMIT_EVENT_I,
  input  wire logic              VLIM_MASK_I,
  input  wire logic              ILIM_MASK_I,
  input  wire logic              OTG_ENABLE_SET_I,
  output logic                   STOP_SWITCHING_O,
  output logic                   SYS_DISCHARGE_O,
  output logic                   CHARGE_EN_O,
  output logic                   BATTERY_SWITCH_ON_O,
  output logic                   SHORT_BAT_CURRENT_O,
  output logic                   THERMAL_REG_STATUS_O,
  output logic                   OTG_ENABLE_O,
  output logic                   BOOST_FAULT_O,
  output logic [RAMP_W-1:0]      BOOST_RAMP_O,
  output logic [7:0]             FAULT_REG_O
);
  localparam int AW = $clog2(ALERT_LOW_CYCLES + ALERT_BLOCK_CYCLES + 1);
  localparam int OW = $clog2(OCP_CYCLES + 1);
  localparam int RW = $clog2(RAMP_STEP_CYCLES + 1);

  alert_state_t al_state;
  slave_state_t sl_state;
  logic [AW-1:0]     al_cnt;
  logic              pending;
  logic              alert_n;
  logic [11:0]       src_q;
  logic [11:0]       src;
  logic              topoff_q;
  logic              event_any;
  logic              otg_en;
  logic              boost_fault;
  logic [2:0]        retry;
  logic [RW-1:0]     ramp_cnt;
  logic [RAMP_W-1:0] ramp;
  logic              tshut;
  logic              depl_latch;
  logic              ocp_latch;
  logic [OW-1:0]     ocp_cnt;
  logic              present_q;
  logic [7:0]        present;
  logic [7:0]        latched;
  logic              read_done;
  logic              scl_q;
  logic              sda_q;
  logic [3:0]        bcnt;
  logic [7:0]        sh;
  logic              sda_pull;

  function automatic logic [1:0] code_of(input logic timer, input logic inov, input logic ts);
    code_of = timer ? `CHG_CODE_TIMER :
              inov  ? `CHG_CODE_INPUT_OV :
              ts    ? `CHG_CODE_TSHUT : `CHG_CODE_NONE;
  endfunction : code_of

  // *************************************
  // Alert sources
  // *************************************
  // event sources; only the two input limits are maskable
  assign src = {WATCHDOG_EXP_I, SAFETY_TIMER_EXP_I, boost_fault, BATTERY_OVERVOLTAGE_I,
                |NTC_FAULT_I, tshut, INPUT_OVERVOLTAGE_I, INPUT_BELOW_MIN_I,
                SYSTEM_OVERVOLTAGE_I, TOPOFF_ACTIVE_I,
                INPUT_VOLTAGE_LIMIT_EVENT_I && !VLIM_MASK_I,
                INPUT_CURRENT_LIMIT_EVENT_I && !ILIM_MASK_I};
  assign event_any = (|(src & ~src_q)) || (topoff_q && !TOPOFF_ACTIVE_I);

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      src_q    <= 12'h000;
      topoff_q <= 1'b0;
    end else begin
      src_q    <= src;
      topoff_q <= TOPOFF_ACTIVE_I;
    end
  end

  // *************************************
  // Alert pulse and blocking window
  // *************************************
  assign LINK.alert_n = alert_n;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      al_state <= AL_IDLE;
      al_cnt   <= '0;
      pending  <= 1'b0;
      alert_n  <= 1'b1;
    end else begin
      case (al_state)
        AL_IDLE: begin
          if (event_any) begin
            al_state <= AL_LOW;
            al_cnt   <= '0;
            alert_n  <= 1'b0;
          end
        end
        AL_LOW: begin
          al_cnt <= al_cnt + 1'b1;
          if (al_cnt == AW'(ALERT_LOW_CYCLES - 1)) begin
            al_state <= AL_BLOCK;
            al_cnt   <= '0;
            alert_n  <= 1'b1;
          end
        end
        AL_BLOCK: begin
          al_cnt <= al_cnt + 1'b1;
          if (event_any) pending <= 1'b1;
          if (al_cnt == AW'(ALERT_BLOCK_CYCLES - 1)) begin
            al_cnt  <= '0;
            pending <= 1'b0;
            if (pending || event_any) begin
              al_state <= AL_LOW;
              alert_n  <= 1'b0;
            end else begin
              al_state <= AL_IDLE;
            end
          end
        end
        default: al_state <= AL_IDLE;
      endcase
    end
  end

  // *************************************
  // Boost control
  // *************************************
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      otg_en      <= 1'b0;
      boost_fault <= 1'b0;
      retry       <= 3'h0;
    end else begin
      if (OTG_ENABLE_SET_I) begin
        otg_en      <= 1'b1;
        boost_fault <= 1'b0;
        retry       <= 3'h0;
      end
      if (otg_en) begin
        if (BOOST_OVP_I) begin
          otg_en      <= 1'b0;
          boost_fault <= 1'b1;
        end else if (BOOST_SHORT_I) begin
          if (retry == `BOOST_RETRY_MAX) begin
            otg_en      <= 1'b0;
            boost_fault <= 1'b1;
          end else begin
            retry <= retry + 3'h1;
          end
        end else if (DIE_OVER_SHUT_I) begin
          otg_en <= 1'b0;
        end
      end
    end
  end

  // soft-start ramp; a short restarts it from zero
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ramp     <= '0;
      ramp_cnt <= '0;
    end else if (!otg_en || BOOST_SHORT_I || BOOST_OVP_I) begin
      ramp     <= '0;
      ramp_cnt <= '0;
    end else if (ramp != {RAMP_W{1'b1}}) begin
      ramp_cnt <= ramp_cnt + 1'b1;
      if (ramp_cnt == RW'(RAMP_STEP_CYCLES - 1)) begin
        ramp_cnt <= '0;
        ramp     <= ramp + 1'b1;
      end
    end
  end

  // *************************************
  // Thermal and battery protection latches
  // *************************************
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tshut      <= 1'b0;
      depl_latch <= 1'b0;
      ocp_latch  <= 1'b0;
      ocp_cnt    <= '0;
      present_q  <= 1'b0;
    end else begin
      present_q <= INPUT_PRESENT_I;
      if (DIE_OVER_SHUT_I) tshut <= 1'b1;
      else if (DIE_BELOW_HYS_I) tshut <= 1'b0;
      if (BAT_DEPLETED_I) depl_latch <= 1'b1;
      else if (INPUT_PRESENT_I && !present_q) depl_latch <= 1'b0;
      ocp_cnt <= BAT_OCP_I ? ((ocp_cnt == OW'(OCP_CYCLES - 1)) ? ocp_cnt : ocp_cnt + 1'b1) : '0;
      if (BAT_OCP_I && ocp_cnt == OW'(OCP_CYCLES - 1)) ocp_latch <= 1'b1;
      else if (SHIP_EXIT_I) ocp_latch <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      STOP_SWITCHING_O     <= 1'b1;
      SYS_DISCHARGE_O      <= 1'b0;
      CHARGE_EN_O          <= 1'b0;
      BATTERY_SWITCH_ON_O  <= 1'b0;
      SHORT_BAT_CURRENT_O  <= 1'b0;
      THERMAL_REG_STATUS_O <= 1'b0;
    end else begin
      STOP_SWITCHING_O     <= INPUT_OVERVOLTAGE_I || SYSTEM_OVERVOLTAGE_I || BOOST_OVP_I
                              || (tshut && !otg_en);
      SYS_DISCHARGE_O      <= SYSTEM_OVERVOLTAGE_I;
      CHARGE_EN_O          <= !BATTERY_OVERVOLTAGE_I && !INPUT_OVERVOLTAGE_I && !tshut && !otg_en;
      BATTERY_SWITCH_ON_O  <= !tshut && !depl_latch && !ocp_latch;
      SHORT_BAT_CURRENT_O  <= BAT_SHORT_I;
      THERMAL_REG_STATUS_O <= DIE_OVER_REG_I;
    end
  end

  // *************************************
  // Fault register: latched view until read
  // *************************************
  // present view: watchdog, boost, fault code, battery, NTC
  assign present = {WATCHDOG_EXP_I, boost_fault,
                    code_of(SAFETY_TIMER_EXP_I, INPUT_OVERVOLTAGE_I, tshut),
                    BATTERY_OVERVOLTAGE_I, NTC_FAULT_I};

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      latched <= 8'h00;
    end else if (read_done) begin
      latched <= present;
    end else begin
      latched[7:6] <= latched[7:6] | present[7:6];
      latched[3:0] <= latched[3:0] | present[3:0];
      if (latched[`FLT_CODE_MSB:`FLT_CODE_LSB] == `CHG_CODE_NONE)
        latched[`FLT_CODE_MSB:`FLT_CODE_LSB] <= present[`FLT_CODE_MSB:`FLT_CODE_LSB];
    end
  end

  // *************************************
  // Two-wire target, read only
  // *************************************
  assign LINK.dev_sda_o  = 1'b0;
  assign LINK.dev_sda_oe = sda_pull;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sl_state  <= SL_IDLE;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      bcnt      <= 4'h0;
      sh        <= 8'h00;
      sda_pull  <= 1'b0;
      read_done <= 1'b0;
    end else begin
      scl_q     <= LINK.scl;
      sda_q     <= LINK.sda;
      read_done <= 1'b0;
      if (scl_q && LINK.scl && sda_q && !LINK.sda) begin
        sl_state <= SL_ADDR;
        bcnt     <= 4'h0;
        sda_pull <= 1'b0;
      end else if (scl_q && LINK.scl && !sda_q && LINK.sda) begin
        sl_state <= SL_IDLE;
        sda_pull <= 1'b0;
      end else begin
        case (sl_state)
          SL_IDLE: sda_pull <= 1'b0;
          SL_ADDR: begin
            if (!scl_q && LINK.scl) begin
              sh   <= {sh[6:0], LINK.sda};
              bcnt <= bcnt + 4'h1;
            end else if (scl_q && !LINK.scl && bcnt == 4'h8) begin
              if (sh[7:1] == `DEV_ADDR && sh[0]) begin
                sda_pull <= 1'b1;
                sl_state <= SL_AACK;
              end else begin
                sl_state <= SL_IDLE;
              end
            end
          end
          SL_AACK: begin
            if (scl_q && !LINK.scl) begin
              sda_pull <= !latched[7];
              sh       <= {latched[6:0], 1'b0};
              bcnt     <= 4'h1;
              sl_state <= SL_TX;
            end
          end
          SL_TX: begin
            if (scl_q && !LINK.scl) begin
              if (bcnt == 4'h8) begin
                sda_pull  <= 1'b0;
                read_done <= 1'b1;
                sl_state  <= SL_MACK;
              end else begin
                sda_pull <= !sh[7];
                sh       <= {sh[6:0], 1'b0};
                bcnt     <= bcnt + 4'h1;
              end
            end
          end
          SL_MACK: begin
            if (!scl_q && LINK.scl) sl_state <= LINK.sda ? SL_IDLE : SL_AACK;
          end
          default: sl_state <= SL_IDLE;
        endcase
      end
    end
  end

  assign OTG_ENABLE_O  = otg_en;
  assign BOOST_FAULT_O = boost_fault;
  assign BOOST_RAMP_O  = ramp;
  assign FAULT_REG_O   = latched;
endmodule : charger_fault_dev
`default_nettype wire

// ### charger_fault_monitor.sv
`default_nettype none
module charger_fault_monitor #(
  parameter int LOW = 20,
  parameter int BLK = 20
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic scl,
  input wire logic alert_n,
  input wire logic dev_sda_oe,
  input wire logic host_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Alert run lengths and link checks
  // ****************************************
  int lo_cnt;
  int hi_cnt;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Gap count saturates so a long idle never wraps
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lo_cnt <= 0;
      hi_cnt <= BLK;
    end else begin
      lo_cnt <= alert_n ? 0 : lo_cnt + 1;
      hi_cnt <= !alert_n ? 0 : (hi_cnt < BLK ? hi_cnt + 1 : BLK);
    end
  end
  a_low_width: assert property ($rose(alert_n) |-> lo_cnt == LOW)
    else $error("alert low width wrong");
  a_gap_width: assert property ($fell(alert_n) |-> hi_cnt >= BLK)
    else $error("alert gap too short");
  a_low_hold: assert property ($fell(alert_n) |=> !alert_n [*8])
    else $error("alert low cut short");
  a_gap_hold: assert property ($rose(alert_n) |-> alert_n [*8])
    else $error("alert gap cut short");
  a_low_bound: assert property (!alert_n |-> ##[1:20] alert_n)
    else $error("alert low stretched");
  a_sda_stable: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device data moved while clock high");
  a_sda_launch: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device pulled data with clock high");
  a_no_fight: assert property (!(dev_sda_oe && host_sda_oe))
    else $error("both ends pull data");
endmodule : charger_fault_monitor
`default_nettype wire

// ### charger_fault_interrupt_logic_tb.sv
`default_nettype none
module charger_fault_interrupt_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOW = 20;
  logic SYS_CLK_I, RESET_N_I, INPUT_OVERVOLTAGE_I, SYSTEM_OVERVOLTAGE_I, BOOST_SHORT_I;
  logic BATTERY_OVERVOLTAGE_I, BOOST_OVP_I, DIE_OVER_REG_I, DIE_OVER_SHUT_I, BAT_OCP_I;
  logic DIE_BELOW_HYS_I, BAT_DEPLETED_I, BAT_SHORT_I, INPUT_PRESENT_I, SHIP_EXIT_I;
  logic SAFETY_TIMER_EXP_I, WATCHDOG_EXP_I, TOPOFF_ACTIVE_I, INPUT_BELOW_MIN_I;
  logic VLIM_MASK_I, ILIM_MASK_I, OTG_ENABLE_SET_I, REG_WR_I, REG_RD_I;
  logic INPUT_VOLTAGE_LIMIT_EVENT_I, INPUT_CURRENT_LIMIT_EVENT_I, SYS_DISCHARGE_O;
  logic STOP_SWITCHING_O, BATTERY_SWITCH_ON_O, THERMAL_REG_STATUS_O;
  logic OTG_ENABLE_O, BOOST_FAULT_O;
  logic [2:0] NTC_FAULT_I;
  logic [1:0] REG_ADDR_I;
  logic [7:0] REG_WDATA_I, REG_RDATA_O, FAULT_REG_O;
  int n_mismatch, check_count, cyc;
  charger_link_if lnk ();
  charger_fault_dev #(.ALERT_LOW_CYCLES(LOW), .ALERT_BLOCK_CYCLES(20), .OCP_CYCLES(10),
    .RAMP_STEP_CYCLES(2)) charger_fault_dev_inst (.SYS_CLK_I, .RESET_N_I, .LINK(lnk),
    .INPUT_OVERVOLTAGE_I, .SYSTEM_OVERVOLTAGE_I, .BATTERY_OVERVOLTAGE_I, .BOOST_SHORT_I,
    .BOOST_OVP_I, .DIE_OVER_REG_I, .DIE_OVER_SHUT_I, .DIE_BELOW_HYS_I, .BAT_DEPLETED_I,
    .BAT_SHORT_I, .BAT_OCP_I, .INPUT_PRESENT_I, .SHIP_EXIT_I, .SAFETY_TIMER_EXP_I,
    .WATCHDOG_EXP_I, .TOPOFF_ACTIVE_I, .INPUT_BELOW_MIN_I, .NTC_FAULT_I,
    .INPUT_VOLTAGE_LIMIT_EVENT_I, .INPUT_CURRENT_LIMIT_EVENT_I, .VLIM_MASK_I,
    .ILIM_MASK_I, .OTG_ENABLE_SET_I, .STOP_SWITCHING_O, .SYS_DISCHARGE_O, .CHARGE_EN_O(),
    .BATTERY_SWITCH_ON_O, .SHORT_BAT_CURRENT_O(), .THERMAL_REG_STATUS_O, .OTG_ENABLE_O,
    .BOOST_FAULT_O, .BOOST_RAMP_O(), .FAULT_REG_O);
  charger_fault_host #(.QTR_CYCLES(4)) charger_fault_host_inst (.SYS_CLK_I, .RESET_N_I,
    .LINK(lnk), .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O);
  charger_fault_monitor #(.LOW(LOW), .BLK(20)) charger_fault_monitor_inst (.SYS_CLK_I,
    .RESET_N_I, .scl(lnk.scl), .alert_n(lnk.alert_n), .dev_sda_oe(lnk.dev_sda_oe),
    .host_sda_oe(lnk.host_sda_oe));
  // ****************************************
  // Shared helpers
  // ****************************************
  always #4 SYS_CLK_I = !SYS_CLK_I;
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  always @(posedge SYS_CLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Everything moves 1 ns after the edge so design updates have landed
  task automatic tick;
    @(posedge SYS_CLK_I);
    #1;
  endtask : tick
  task automatic span(input logic v, output int n);
    n = 0;
    while (lnk.alert_n === v && n < 200) begin
      tick;
      n++;
    end
  endtask : span
  // Strobe stays up; the caller drops it
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    tick;
    d = REG_RDATA_O;
  endtask : rd
  task automatic fetch(output logic [7:0] d);
    logic [7:0] s;
    REG_ADDR_I <= 2'h0;
    REG_WDATA_I <= 8'h01;
    REG_WR_I <= 1'b1;
    tick;
    REG_WR_I <= 1'b0;
    s = 8'h01;
    for (int i = 0; i < 600 && s[0]; i++) rd(2'h1, s);
    rd(2'h2, d);
    REG_RD_I <= 1'b0;
  endtask : fetch
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_alert;
    int n;
    BATTERY_OVERVOLTAGE_I <= 1'b1;
    span(1'b1, n);
    chk(n < 4, 1'b1);
    repeat (3) tick;
    WATCHDOG_EXP_I <= 1'b1;
    span(1'b0, n);
    chk(n, LOW - 3);
    span(1'b1, n);
    chk(n, 200);
    chk(FAULT_REG_O, 8'h88);
    {BATTERY_OVERVOLTAGE_I, WATCHDOG_EXP_I} <= 2'b00;
  endtask : t_alert
  task automatic t_read;
    logic [7:0] d;
    fetch(d);
    chk(d, 8'h88);
    fetch(d);
    chk(d, 8'h00);
  endtask : t_read
  task automatic t_defer;
    int n;
    INPUT_BELOW_MIN_I <= 1'b1;
    span(1'b1, n);
    span(1'b0, n);
    repeat (5) tick;
    TOPOFF_ACTIVE_I <= 1'b1;
    span(1'b1, n);
    chk(n > 13 && n < 17, 1'b1);
    span(1'b0, n);
    chk(n, LOW);
    {INPUT_BELOW_MIN_I, TOPOFF_ACTIVE_I} <= 2'b00;
    repeat (60) tick;
  endtask : t_defer
  task automatic t_mask;
    int n;
    for (int i = 0; i < 2; i++) begin
      {VLIM_MASK_I, ILIM_MASK_I} <= 2'b11;
      {INPUT_CURRENT_LIMIT_EVENT_I, INPUT_VOLTAGE_LIMIT_EVENT_I} <= 2'(1 << i);
      span(1'b1, n);
      chk(n, 200);
      {INPUT_CURRENT_LIMIT_EVENT_I, INPUT_VOLTAGE_LIMIT_EVENT_I} <= 2'b00;
      tick;
      {VLIM_MASK_I, ILIM_MASK_I} <= 2'b00;
      {INPUT_CURRENT_LIMIT_EVENT_I, INPUT_VOLTAGE_LIMIT_EVENT_I} <= 2'(1 << i);
      span(1'b1, n);
      chk(n < 4, 1'b1);
      {INPUT_CURRENT_LIMIT_EVENT_I, INPUT_VOLTAGE_LIMIT_EVENT_I} <= 2'b00;
      repeat (60) tick;
    end
  endtask : t_mask
  task automatic t_code;
    logic [7:0] d;
    fetch(d);
    INPUT_OVERVOLTAGE_I <= 1'b1;
    repeat (3) tick;
    chk(STOP_SWITCHING_O, 1'b1);
    INPUT_OVERVOLTAGE_I <= 1'b0;
    fetch(d);
    chk(d[5:4], 2'h1);
    fetch(d);
    SAFETY_TIMER_EXP_I <= 1'b1;
    fetch(d);
    chk(d[5:4], 2'h3);
    SAFETY_TIMER_EXP_I <= 1'b0;
  endtask : t_code
  task automatic t_boost;
    OTG_ENABLE_SET_I <= 1'b1;
    tick;
    OTG_ENABLE_SET_I <= 1'b0;
    for (int i = 1; i <= 8; i++) begin
      BOOST_SHORT_I <= 1'b1;
      tick;
      BOOST_SHORT_I <= 1'b0;
      repeat (2) tick;
      chk(BOOST_FAULT_O, i == 8);
    end
    chk(OTG_ENABLE_O, 1'b0);
    OTG_ENABLE_SET_I <= 1'b1;
    tick;
    OTG_ENABLE_SET_I <= 1'b0;
    repeat (2) tick;
    chk(BOOST_FAULT_O, 1'b0);
    BOOST_OVP_I <= 1'b1;
    repeat (2) tick;
    chk({BOOST_FAULT_O, OTG_ENABLE_O}, 2'b10);
    BOOST_OVP_I <= 1'b0;
  endtask : t_boost
  task automatic t_prot;
    {SYSTEM_OVERVOLTAGE_I, DIE_OVER_REG_I, BAT_OCP_I} <= 3'h7;
    repeat (6) tick;
    chk(SYS_DISCHARGE_O, 1'b1);
    chk(THERMAL_REG_STATUS_O, 1'b1);
    chk(BATTERY_SWITCH_ON_O, 1'b1);
    repeat (8) tick;
    chk(BATTERY_SWITCH_ON_O, 1'b0);
    {SYSTEM_OVERVOLTAGE_I, DIE_OVER_REG_I, BAT_OCP_I} <= 3'h0;
    SHIP_EXIT_I <= 1'b1;
    tick;
    SHIP_EXIT_I <= 1'b0;
    repeat (2) tick;
    chk(BATTERY_SWITCH_ON_O, 1'b1);
    DIE_OVER_SHUT_I <= 1'b1;
    repeat (2) tick;
    chk({BATTERY_SWITCH_ON_O, STOP_SWITCHING_O}, 2'b01);
  endtask : t_prot
  initial begin
    {SYS_CLK_I, RESET_N_I, INPUT_OVERVOLTAGE_I, SYSTEM_OVERVOLTAGE_I, BOOST_SHORT_I,
      BATTERY_OVERVOLTAGE_I, BOOST_OVP_I, DIE_OVER_REG_I, DIE_OVER_SHUT_I, BAT_OCP_I,
      DIE_BELOW_HYS_I, BAT_DEPLETED_I, BAT_SHORT_I, SHIP_EXIT_I, SAFETY_TIMER_EXP_I,
      WATCHDOG_EXP_I, TOPOFF_ACTIVE_I, INPUT_BELOW_MIN_I, VLIM_MASK_I, ILIM_MASK_I,
      OTG_ENABLE_SET_I, REG_WR_I, REG_RD_I, INPUT_VOLTAGE_LIMIT_EVENT_I,
      INPUT_CURRENT_LIMIT_EVENT_I, NTC_FAULT_I, REG_ADDR_I, REG_WDATA_I} = '0;
    INPUT_PRESENT_I = 1'b1;
    repeat (4) tick;
    RESET_N_I <= 1'b1;
    tick;
    t_alert;
    t_read;
    t_defer;
    t_mask;
    t_code;
    t_boost;
    t_prot;
    give_verdict;
  end
endmodule : charger_fault_interrupt_logic_tb
`default_nettype wire
